// ===== src/oscillator_select_control.sv
// Operation
// - multiplier field bits 18:16 codes map to factors 15..21 and 24
// - current-source field bits 14:12 reports active clock per eight codes
// - new-source field bits 10:8 holds requested source, same encoding
// - any reset loads new-source field from config word one bits 2:0
// - monitor config 1x: selection lock set freezes clock and pll selections
// - monitor config 0x: selections never locked regardless of lock bit
// - bit 6 reads usb pll locked or its start-up timer done
// - bit 5 reads system pll locked or its start-up timer done
// - bit 4 set means wait enters sleep, clear means idle
// - bit 3 set when fail-safe monitor detects a clock failure
// - control writes accepted only after a completed unlock sequence with no other write since; reads in between do not cancel it
// - bits 15 and 11 unimplemented, read zero
`timescale 1ns/1ps
module oscillator_select_control (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // configuration word
  input  wire logic [2:0]  initial_source_config_i,
  input  wire logic [1:0]  switch_monitor_config_i,
  // oscillator and pll side
  input  wire logic        usb_pll_locked_i,
  input  wire logic        sys_pll_locked_i,
  input  wire logic        clock_failure_i,
  input  wire logic        switch_done_i,
  output logic             switch_req_o,
  output logic      [2:0]  new_source_select_o,
  output logic      [2:0]  current_source_select_o,
  output logic      [4:0]  pll_factor_o,
  output logic             deep_sleep_select_o,
  // interrupt
  output logic             irq_o
);

  localparam int EV_W = osc_sel_pkg::EV_WIDTH;

  // ==========================================
  // control fields
  logic [2:0]  mult_q;
  logic [2:0]  new_source_select_q;
  logic [2:0]  current_source_select_q;
  logic        lock_q;
  logic        sleep_q;
  logic        fail_q;
  logic        usb_lk_q;
  logic        sys_lk_q;
  logic [1:0]  unlock_q;
  logic        cfg_pending_q;
  logic [EV_W-1:0] stat_q;
  logic [EV_W-1:0] mask_q;
  logic [4:0]  factor_d;
  logic        sel_frozen;
  logic        ctl_wr;
  logic [31:0] ctl_word;
  logic [EV_W-1:0] ev;
  osc_sel_pkg::switch_state_type sw_q;

  // ==========================================
  // write gating
  // a stray bus access between keys restarts the unlock sequence
  assign ctl_wr = wr_i && (addr_i == osc_sel_pkg::ADDR_CONTROL) && unlock_q == 2'd2;
  assign sel_frozen = switch_monitor_config_i[1] && lock_q;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      unlock_q <= 2'd0;
    end else if (wr_i && addr_i == osc_sel_pkg::ADDR_UNLOCK &&
                 wdata_i == osc_sel_pkg::UNLOCK_KEY1) begin
      unlock_q <= 2'd1;
    end else if (wr_i && addr_i == osc_sel_pkg::ADDR_UNLOCK &&
                 wdata_i == osc_sel_pkg::UNLOCK_KEY2 && unlock_q == 2'd1) begin
      unlock_q <= 2'd2;
    end else if (wr_i || (rd_i && unlock_q != 2'd2)) begin
      unlock_q <= 2'd0;
    end
  end

  // ==========================================
  // configuration capture after reset release
  // async reset cannot load a port, so the strap is caught on the first edge
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_pending_q <= 1'b1;
    end else begin
      cfg_pending_q <= 1'b0;
    end
  end

  // ==========================================
  // selection fields
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      new_source_select_q <= 3'h0;
      mult_q <= osc_sel_pkg::MULT_RESET;
    end else if (cfg_pending_q) begin
      new_source_select_q <= initial_source_config_i;
    end else if (ctl_wr && !sel_frozen) begin
      new_source_select_q <= wdata_i[osc_sel_pkg::NEW_SOURCE_SELECT_LSB +: 3];
      mult_q <= wdata_i[osc_sel_pkg::MULT_LSB +: 3];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_q  <= 1'b0;
      sleep_q <= 1'b0;
    end else if (ctl_wr) begin
      sleep_q <= wdata_i[osc_sel_pkg::SLEEP_BIT];
      if (!lock_q || !switch_monitor_config_i[1]) begin
        lock_q <= wdata_i[osc_sel_pkg::LOCK_BIT];
      end
    end
  end

  // ==========================================
  // clock switch sequencing
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sw_q         <= osc_sel_pkg::SW_IDLE;
      current_source_select_q       <= 3'h0;
      switch_req_o <= 1'b0;
    end else begin
      case (sw_q)
        osc_sel_pkg::SW_IDLE: begin
          if (cfg_pending_q) begin
            current_source_select_q <= initial_source_config_i;
          end else if (ctl_wr && !sel_frozen && wdata_i[osc_sel_pkg::SWITCH_BIT]) begin
            sw_q         <= osc_sel_pkg::SW_WAIT;
            switch_req_o <= 1'b1;
          end
        end
        osc_sel_pkg::SW_WAIT: begin
          if (switch_done_i) begin
            current_source_select_q       <= new_source_select_q;
            switch_req_o <= 1'b0;
            sw_q         <= osc_sel_pkg::SW_IDLE;
          end
        end
        default: begin
          sw_q         <= osc_sel_pkg::SW_IDLE;
          switch_req_o <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================
  // status sampling
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      usb_lk_q <= 1'b0;
      sys_lk_q <= 1'b0;
      fail_q   <= 1'b0;
    end else begin
      usb_lk_q <= usb_pll_locked_i;
      sys_lk_q <= sys_pll_locked_i;
      if (clock_failure_i) begin
        fail_q <= 1'b1;
      end
    end
  end

  // ==========================================
  // interrupts: set wins over read-clear
  always_comb begin
    ev = '0;
    ev[osc_sel_pkg::EV_FAIL]     = clock_failure_i && !fail_q;
    ev[osc_sel_pkg::EV_SWITCH]   = (sw_q == osc_sel_pkg::SW_WAIT) && switch_done_i;
    ev[osc_sel_pkg::EV_SYS_LOST] = sys_lk_q && !sys_pll_locked_i;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stat_q <= '0;
    end else if (rd_i && addr_i == osc_sel_pkg::ADDR_IRQ_STAT) begin
      stat_q <= ev;
    end else begin
      stat_q <= stat_q | ev;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_q <= '0;
    end else if (wr_i && addr_i == osc_sel_pkg::ADDR_IRQ_MASK) begin
      mask_q <= wdata_i[EV_W-1:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(((stat_q | ev) & ~((rd_i && addr_i == osc_sel_pkg::ADDR_IRQ_STAT) ?
                stat_q & ~ev : '0)) & mask_q);
    end
  end

  // ==========================================
  // read path
  always_comb begin
    ctl_word = osc_sel_pkg::ZERO_WORD;
    ctl_word[osc_sel_pkg::MULT_LSB +: 3] = mult_q;
    ctl_word[osc_sel_pkg::CURRENT_SOURCE_SELECT_LSB +: 3] = current_source_select_q;
    ctl_word[osc_sel_pkg::NEW_SOURCE_SELECT_LSB +: 3] = new_source_select_q;
    ctl_word[osc_sel_pkg::LOCK_BIT]      = lock_q;
    ctl_word[osc_sel_pkg::USB_LK_BIT]    = usb_lk_q;
    ctl_word[osc_sel_pkg::SYS_LK_BIT]    = sys_lk_q;
    ctl_word[osc_sel_pkg::SLEEP_BIT]     = sleep_q;
    ctl_word[osc_sel_pkg::FAIL_BIT]      = fail_q;
    ctl_word[osc_sel_pkg::SWITCH_BIT]    = (sw_q == osc_sel_pkg::SW_WAIT);
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= osc_sel_pkg::ZERO_WORD;
    end else if (rd_i) begin
      case (addr_i)
        osc_sel_pkg::ADDR_CONTROL:  rdata_o <= ctl_word;
        osc_sel_pkg::ADDR_IRQ_STAT: rdata_o <= {{(32-EV_W){1'b0}}, stat_q};
        osc_sel_pkg::ADDR_IRQ_MASK: rdata_o <= {{(32-EV_W){1'b0}}, mask_q};
        default:                    rdata_o <= osc_sel_pkg::ZERO_WORD;
      endcase
    end else begin
      rdata_o <= osc_sel_pkg::ZERO_WORD;
    end
  end

  // ==========================================
  // multiplier decode
  always_comb begin
    case (mult_q)
      3'h0:    factor_d = 5'd15;
      3'h1:    factor_d = 5'd16;
      3'h2:    factor_d = 5'd17;
      3'h3:    factor_d = 5'd18;
      3'h4:    factor_d = 5'd19;
      3'h5:    factor_d = 5'd20;
      3'h6:    factor_d = 5'd21;
      default: factor_d = 5'd24;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pll_factor_o            <= 5'd15;
      new_source_select_o     <= 3'h0;
      current_source_select_o <= 3'h0;
      deep_sleep_select_o     <= 1'b0;
    end else begin
      pll_factor_o            <= factor_d;
      new_source_select_o     <= new_source_select_q;
      current_source_select_o <= current_source_select_q;
      deep_sleep_select_o     <= sleep_q;
    end
  end

endmodule

// ===== include/osc_sel_pkg.sv
package osc_sel_pkg;
  // ==========================================
  // register map
  localparam logic [7:0]  ADDR_CONTROL   = 8'h00;
  localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h04;
  localparam logic [7:0]  ADDR_IRQ_MASK  = 8'h08;
  localparam logic [7:0]  ADDR_UNLOCK    = 8'h0C;
  // ==========================================
  // unlock sequence keys
  localparam logic [31:0] UNLOCK_KEY1    = 32'hAA99_6655;
  localparam logic [31:0] UNLOCK_KEY2    = 32'h5566_99AA;
  // ==========================================
  // field positions
  localparam int MULT_LSB    = 16;
  localparam int CURRENT_SOURCE_SELECT_LSB    = 12;
  localparam int NEW_SOURCE_SELECT_LSB    = 8;
  localparam int LOCK_BIT    = 7;
  localparam int USB_LK_BIT  = 6;
  localparam int SYS_LK_BIT  = 5;
  localparam int SLEEP_BIT   = 4;
  localparam int FAIL_BIT    = 3;
  localparam int SWITCH_BIT  = 0;
  // ==========================================
  // interrupt status bits
  localparam int EV_FAIL     = 0;
  localparam int EV_SWITCH   = 1;
  localparam int EV_SYS_LOST = 2;
  localparam int EV_WIDTH    = 3;
  // ==========================================
  // reset values
  localparam logic [2:0]  MULT_RESET     = 3'h0;
  localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;
  // ==========================================
  // switch state machine
  typedef enum logic [1:0] {
    SW_IDLE = 2'b00,
    SW_WAIT = 2'b01
  } switch_state_type;
endpackage

// ===== verif/osc_sel_props.sv
`timescale 1ns/1ps
module osc_sel_props (
  // clock, reset and bus
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  input wire logic [7:0]  addr_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  // sources and status
  input wire logic [2:0]  initial_source_config_i,
  input wire logic        usb_pll_locked_i,
  input wire logic        sys_pll_locked_i,
  input wire logic        clock_failure_i,
  input wire logic        switch_done_i,
  input wire logic        switch_req_o,
  input wire logic [2:0]  new_source_select_o,
  input wire logic [2:0]  current_source_select_o,
  input wire logic [4:0]  pll_factor_o,
  input wire logic        deep_sleep_select_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence ctl_rd;
    rd_i && addr_i == 8'h00;
  endsequence
  sequence sw_end;
    switch_done_i && switch_req_o;
  endsequence
  factor_table_a: assert property (pll_factor_o inside {[5'd15:5'd21], 5'd24})
    else $error("pll factor outside table");
  source_reload_a: assert property ($rose(rst_n_i) |-> ##2
    new_source_select_o == initial_source_config_i) else $error("new source not reloaded");
  reserved_zero_a: assert property (ctl_rd |=> !rdata_o[15] && !rdata_o[11])
    else $error("unimplemented bit reads one");
  switch_hold_a: assert property (switch_req_o && !switch_done_i |=> switch_req_o)
    else $error("switch request dropped early");
  switch_end_a: assert property (sw_end |-> ##[1:3]
    (!switch_req_o && current_source_select_o == new_source_select_o)) else $error("switch end");
  sleep_cause_a: assert property ($changed(deep_sleep_select_o) |->
    $past(wr_i, 2) && $past(addr_i, 2) == 8'h00) else $error("sleep select moved alone");
  fail_sticky_a: assert property ($past(clock_failure_i, 2) ##0 ctl_rd |=> rdata_o[3])
    else $error("failure flag missing");
  pll_status_a: assert property ($stable({usb_pll_locked_i, sys_pll_locked_i}) ##0 ctl_rd
    |=> rdata_o[6:5] == $past({usb_pll_locked_i, sys_pll_locked_i})) else $error("pll status");
endmodule
bind oscillator_select_control osc_sel_props chk (.sys_clk_i, .rst_n_i, .addr_i, .wr_i, .rd_i,
  .rdata_o, .initial_source_config_i, .usb_pll_locked_i, .sys_pll_locked_i, .clock_failure_i,
  .switch_done_i, .switch_req_o, .new_source_select_o, .current_source_select_o, .pll_factor_o,
  .deep_sleep_select_o);

// ===== verif/osc_partner.sv
`timescale 1ns/1ps
module osc_partner (
  // clock, reset and knobs
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [7:0] delay_i,
  input  wire logic [1:0] en_i,
  // block side
  input  wire logic       switch_req_i,
  output logic            switch_done_o,
  output logic [1:0]      locked_o
);
  logic [7:0] wait_q;
  logic       fired_q;
  logic [3:0] t_q [2];
  // ==========================================
  // one done pulse per request, slow or prompt
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_q        <= 8'h00;
      fired_q       <= 1'b0;
      switch_done_o <= 1'b0;
    end else begin
      switch_done_o <= 1'b0;
      if (!switch_req_i) begin
        wait_q  <= 8'h00;
        fired_q <= 1'b0;
      end else if (!fired_q && wait_q >= delay_i) begin
        switch_done_o <= 1'b1;
        fired_q       <= 1'b1;
      end else if (!fired_q) begin
        wait_q <= wait_q + 8'h01;
      end
    end
  end
  // ==========================================
  // start-up timers; lock drops at once on disable
  for (genvar g = 0; g < 2; g++) begin : pll
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) t_q[g] <= 4'h0;
      else t_q[g] <= !en_i[g] ? 4'h0 : (t_q[g] == 4'h6 ? t_q[g] : t_q[g] + 4'h1);
    end
    assign locked_o[g] = (t_q[g] == 4'h6);
  end
endmodule

// ===== verif/tb.sv
`timescale 1ns/1ps
module tb;
  logic        sys_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [2:0]  initial_source_config_i = 3'h0;
  logic [1:0]  switch_monitor_config_i = 2'h0;
  logic        clock_failure_i = 1'b0;
  logic [7:0]  delay = 8'h00;
  logic [1:0]  en = 2'h0;
  logic [31:0] rdata_o, got;
  logic        usb_pll_locked_i, sys_pll_locked_i, switch_done_i, switch_req_o;
  logic        deep_sleep_select_o, irq_o;
  logic [2:0]  new_source_select_o, current_source_select_o;
  logic [4:0]  pll_factor_o;
  int          miscompares = 0;
  int          check_count = 0;
  int          m_mult, m_cur, m_new, m_lock, m_sleep, m_fail, m_usb, m_sys, m_busy, k;
  int          fac [8] = '{15, 16, 17, 18, 19, 20, 21, 24};
  always #12.5 sys_clk_i = ~sys_clk_i;
  oscillator_select_control uut (.sys_clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .initial_source_config_i, .switch_monitor_config_i, .usb_pll_locked_i, .sys_pll_locked_i,
    .clock_failure_i, .switch_done_i, .switch_req_o, .new_source_select_o,
    .current_source_select_o, .pll_factor_o, .deep_sleep_select_o, .irq_o);
  osc_partner far (.clk_i(sys_clk_i), .rst_n_i, .delay_i(delay), .en_i(en),
    .switch_req_i(switch_req_o), .switch_done_o(switch_done_i),
    .locked_o({usb_pll_locked_i, sys_pll_locked_i}));
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic w);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= w;
    rd_i <= !w;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    #1 got = rdata_o;
  endtask
  function automatic logic [31:0] ctl_exp();
    return 32'((m_mult << 16) | (m_cur << 12) | (m_new << 8) | (m_lock << 7) | (m_usb << 6)
      | (m_sys << 5) | (m_sleep << 4) | (m_fail << 3) | m_busy);
  endfunction
  task automatic ctl_chk();
    bus(8'h00, 32'h0000_0000, 1'b0);
    check(got, ctl_exp());
  endtask
  // locked fields keep old values; sleep select is never frozen
  task automatic ctl_write(input logic [31:0] d);
    bus(8'h0C, 32'hAA99_6655, 1'b1);
    bus(8'h0C, 32'h5566_99AA, 1'b1);
    bus(8'h00, d, 1'b1);
    if (!(m_lock && switch_monitor_config_i[1])) begin
      m_mult = d[18:16];
      m_new = d[10:8];
      m_lock = d[7];
      m_busy = m_busy | d[0];
    end
    m_sleep = d[4];
  endtask
  initial begin
    void'($urandom(32'h4c9d_5960));
    initial_source_config_i = 3'($urandom % 8);
    repeat (10) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    m_new = initial_source_config_i;
    m_cur = m_new;
    repeat (4) @(posedge sys_clk_i);
    ctl_chk();
    bus(8'h00, 32'h0007_0010, 1'b1);
    ctl_chk();
    for (int i = 0; i < 8; i++) begin
      ctl_write({13'h0, 3'(i), 5'h0, 3'($urandom % 8), 3'h0, 1'(i), 4'h0});
      ctl_chk();
      check(32'(pll_factor_o), 32'(fac[i]));
      check(32'(deep_sleep_select_o), 32'(i % 2));
    end
    bus(8'h08, 32'h0000_0002, 1'b1);
    for (int j = 0; j < 2; j++) begin
      delay <= 8'(j * 20);
      ctl_write({21'h0, 3'($urandom % 8), 7'h0, 1'b1});
      if (j == 1) ctl_chk();
      for (k = 0; k < 400 && switch_req_o !== 1'b0; k++) @(posedge sys_clk_i);
      if (k == 400) begin
        miscompares++;
        results();
      end
      m_busy = 0;
      m_cur = m_new;
      repeat (3) @(posedge sys_clk_i);
      ctl_chk();
      check(32'(current_source_select_o), 32'(m_cur));
      check(32'(new_source_select_o), 32'(m_new));
      check(32'(irq_o), 32'h0000_0001);
      bus(8'h04, 32'h0000_0000, 1'b0);
      check(got, 32'h0000_0002);
      repeat (2) @(posedge sys_clk_i);
      check(32'(irq_o), 32'h0000_0000);
    end
    switch_monitor_config_i <= 2'b10;
    ctl_write(32'h0003_0080);
    ctl_write(32'h0005_0210);
    ctl_chk();
    switch_monitor_config_i <= 2'b00;
    ctl_write(32'h0006_0300);
    ctl_chk();
    en <= 2'b11;
    repeat (10) @(posedge sys_clk_i);
    m_usb = 1;
    m_sys = 1;
    ctl_chk();
    en <= 2'b10;
    repeat (3) @(posedge sys_clk_i);
    m_sys = 0;
    ctl_chk();
    clock_failure_i <= 1'b1;
    @(posedge sys_clk_i);
    clock_failure_i <= 1'b0;
    m_fail = 1;
    ctl_chk();
    bus(8'h10, 32'h0000_0000, 1'b0);
    check(got, 32'h0000_0000);
    results();
  end
endmodule
